// File: rtl/doah_access_if.sv
/*
 * Access strobes passed from the host pin synchroniser to the
 * register block. Assumes both ends share one clock.
 */
`timescale 1ns/1ns
interface doah_access_if;
  logic        start;
  logic        finish;
  logic        write;
  logic [13:0] addr;
  logic [15:0] wdata;

  modport port (output start, finish, write, addr, wdata);
  modport regs (input  start, finish, write, addr, wdata);
endinterface

// File: rtl/doah_host_sync.sv
/*
 * Brings the asynchronous host port pins into the clock domain and
 * turns chip select edges into one-cycle start and finish pulses.
 * Assumes address, direction and data settle before select falls.
 */
`timescale 1ns/1ns
module doah_host_sync (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // host pins
  input  wire logic        host_cs_n,
  input  wire logic        host_rd,
  input  wire logic [13:0] host_addr,
  input  wire logic [15:0] host_data_in,
  // access strobes
  doah_access_if.port      acc
);

  logic [31:0] s1_reg, s1_next;
  logic [31:0] s2_reg, s2_next;
  logic        cs_old_reg, cs_old_next;

  // two stages on every pin; the first stage feeds only the second
  always_comb begin
    s1_next     = {host_cs_n, host_rd, host_addr, host_data_in};
    s2_next     = s1_reg;
    cs_old_next = s2_reg[31];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg     <= 32'hffff_ffff;
      s2_reg     <= 32'hffff_ffff;
      cs_old_reg <= 1'b1;
    end else begin
      s1_reg     <= s1_next;
      s2_reg     <= s2_next;
      cs_old_reg <= cs_old_next;
    end
  end

  // edge pulses from the settled stage only
  assign acc.start  = cs_old_reg & ~s2_reg[31];
  assign acc.finish = ~cs_old_reg & s2_reg[31];
  assign acc.write  = ~s2_reg[30];
  assign acc.addr   = s2_reg[29:16];
  assign acc.wdata  = s2_reg[15:0];

endmodule

// File: rtl/doah_pkg.sv
/*
 * Constants for the phase/skew adjust and housekeeping register block.
 * Assumes a 16-bit parallel host port and one 125 MHz system clock.
 */
package doah_pkg;

  // ************************************************************
  // port geometry and register map
  // ************************************************************
  localparam int ADDR_W = 14;
  localparam int DATA_W = 16;
  localparam logic [13:0] OFS_ADJUST = 14'h002d;
  localparam logic [13:0] OFS_HOUSE  = 14'h002e;
  localparam logic [15:0] ADJ_RESET  = 16'h0000;
  localparam logic [15:0] HK_RESET   = 16'h0000;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int PHASE_MSB = 15;
  localparam int PHASE_LSB = 9;
  localparam int SKEW_MSB  = 2;
  localparam int SKEW_LSB  = 0;
  localparam int HK_RSV_LSB = 7;
  localparam int HK_SEC_BIT = 6;
  localparam int HK_PRI_BIT = 5;
  localparam int HK_CLK_BIT = 4;
  localparam int HK_LIM_BIT = 3;
  localparam int HK_ST_MSB  = 2;

  // ************************************************************
  // step sizes, in ps, and the shift resolution they share
  // ************************************************************
  localparam int STEP_FAST_PS = 15000;
  localparam int STEP_T1_PS   = 20000;
  localparam int SKEW_STEP_PS = 3500;
  localparam int SHIFT_RES_PS = 500;
  localparam int MUL_FAST = STEP_FAST_PS / SHIFT_RES_PS;
  localparam int MUL_T1   = STEP_T1_PS / SHIFT_RES_PS;
  localparam int MUL_SKEW = SKEW_STEP_PS / SHIFT_RES_PS;
  localparam int SHIFT_W  = 13;

  // ************************************************************
  // active reference frequency codes and pll state codes
  // ************************************************************
  localparam logic [1:0] REF_8K    = 2'h0;
  localparam logic [1:0] REF_1M544 = 2'h1;
  localparam logic [1:0] REF_2M048 = 2'h2;
  localparam logic [2:0] ST_TRACK_FIRST   = 3'h0;
  localparam logic [2:0] ST_HOLD_FIRST    = 3'h2;
  localparam logic [2:0] ST_REALIGN_FIRST = 3'h3;
  localparam logic [2:0] ST_TRACK_SECOND  = 3'h4;
  localparam logic [2:0] ST_HOLD_SECOND   = 3'h6;
  localparam logic [2:0] ST_REALIGN_SECOND = 3'h7;

  // host access sequencer
  typedef enum logic [1:0] {
    HS_IDLE = 2'b01,
    HS_HOLD = 2'b10
  } doah_hstate_t;

endpackage

// File: rtl/doah_shift_calc.sv
/*
 * Converts phase word and skew count into one output shift in
 * 0.5 ns units. Pure logic; assumes inputs come from registers.
 */
`timescale 1ns/1ns
module doah_shift_calc (
  // settings
  input  wire logic        [6:0]  phase_word,
  input  wire logic        [2:0]  skew_steps,
  input  wire logic        [1:0]  ref_freq,
  // result
  output logic signed      [12:0] shift
);

  logic signed [12:0] mul;
  logic signed [12:0] ph;
  logic signed [12:0] sk;

  // step size depends on which reference the pll follows
  always_comb begin
    mul = (ref_freq == doah_pkg::REF_1M544)
        ? 13'(doah_pkg::MUL_T1) : 13'(doah_pkg::MUL_FAST);
    ph  = 13'(signed'(phase_word)) * mul;
    sk  = 13'(skew_steps) * 13'(doah_pkg::MUL_SKEW);
    shift = ph + sk;
  end

endmodule

// File: rtl/doah_top.sv
/*
 * Phase/skew adjust and pll housekeeping registers on the parallel
 * host port. Assumes pll status inputs are on this clock and that
 * the host holds address and data stable while select is low.
 */
//
// Notes on behaviour
// - bits 15..9 are signed phase word
// - phase step 15 ns on 8k/2.048M
// - phase step 20 ns on 1.544M
// - bits 2..0 skew 0..7 of 3.5ns
// - bit 6 shows secondary monitor fail
// - bit 5 shows primary monitor fail
// - bit 4 selects fast main clock
// - only bit 4 of housekeeping writable
// - bit 3 shows slope limiter active
// - bits 2..0 report pll state code
// - housekeeping at 002e, resets zero
`timescale 1ns/1ns
module doah_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // host parallel port
  input  wire logic        host_cs_n,
  input  wire logic        host_rd,
  input  wire logic [13:0] host_addr,
  input  wire logic [15:0] host_data_in,
  output logic      [15:0] host_data_out,
  output logic             host_data_oe,
  output logic             host_ack_n,
  // pll status
  input  wire logic        second_monitor_fail,
  input  wire logic        first_monitor_fail,
  input  wire logic        limiter_active,
  input  wire logic [2:0]  pll_state,
  input  wire logic [1:0]  active_ref_freq,
  // pll controls
  output logic      [6:0]  phase_offset_word,
  output logic      [2:0]  output_skew_steps,
  output logic             fast_clock_select,
  output logic signed [12:0] output_shift
);

  // ************************************************************
  // host pin synchroniser
  // ************************************************************
  doah_access_if acc ();

  doah_host_sync u_sync (
    .clk          (clk),
    .rst_n        (rst_n),
    .host_cs_n    (host_cs_n),
    .host_rd      (host_rd),
    .host_addr    (host_addr),
    .host_data_in (host_data_in),
    .acc          (acc)
  );

  // ************************************************************
  // state
  // ************************************************************
  doah_pkg::doah_hstate_t hs_reg, hs_next;
  logic [6:0]  phase_reg, phase_next;
  logic [2:0]  skew_reg,  skew_next;
  logic        fast_reg,  fast_next;
  logic [15:0] dout_reg,  dout_next;
  logic        oe_reg,    oe_next;
  logic        ack_n_reg, ack_n_next;
  logic signed [12:0] shift_reg, shift_next;
  logic signed [12:0] shift_calc;
  logic [15:0] hk_view;
  logic        hit_adj;
  logic        hit_hk;

  // decode of the two registers; other addresses read as zero
  assign hit_adj = (acc.addr == doah_pkg::OFS_ADJUST);
  assign hit_hk  = (acc.addr == doah_pkg::OFS_HOUSE);

  // live housekeeping image; status bits come straight from the pll
  always_comb begin
    hk_view = doah_pkg::HK_RESET;
    hk_view[doah_pkg::HK_SEC_BIT] = second_monitor_fail;
    hk_view[doah_pkg::HK_PRI_BIT] = first_monitor_fail;
    hk_view[doah_pkg::HK_CLK_BIT] = fast_reg;
    hk_view[doah_pkg::HK_LIM_BIT] = limiter_active;
    hk_view[doah_pkg::HK_ST_MSB:0] = pll_state;
  end

  // ************************************************************
  // output shift arithmetic
  // ************************************************************
  doah_shift_calc u_calc (
    .phase_word (phase_reg),
    .skew_steps (skew_reg),
    .ref_freq   (active_ref_freq),
    .shift      (shift_calc)
  );

  // ************************************************************
  // register writes and host sequencing
  // ************************************************************
  // reserved bits are dropped, not stored, so a careless host
  // cannot upset anything downstream
  always_comb begin
    hs_next    = hs_reg;
    phase_next = phase_reg;
    skew_next  = skew_reg;
    fast_next  = fast_reg;
    dout_next  = dout_reg;
    oe_next    = oe_reg;
    ack_n_next = ack_n_reg;
    shift_next = shift_calc;
    unique case (hs_reg)
      doah_pkg::HS_IDLE: begin
        if (acc.start) begin
          hs_next    = doah_pkg::HS_HOLD;
          ack_n_next = 1'b0;
          oe_next    = ~acc.write;
          dout_next  = 16'h0000;
          if (acc.write && hit_adj) begin
            phase_next = acc.wdata[doah_pkg::PHASE_MSB:
                                   doah_pkg::PHASE_LSB];
            skew_next  = acc.wdata[doah_pkg::SKEW_MSB:
                                   doah_pkg::SKEW_LSB];
          end
          if (acc.write && hit_hk) begin
            fast_next = acc.wdata[doah_pkg::HK_CLK_BIT];
          end
          if (!acc.write && hit_adj) begin
            dout_next[doah_pkg::PHASE_MSB:doah_pkg::PHASE_LSB]
              = phase_reg;
            dout_next[doah_pkg::SKEW_MSB:doah_pkg::SKEW_LSB]
              = skew_reg;
          end
          if (!acc.write && hit_hk) begin
            dout_next = hk_view;
          end
        end
      end
      doah_pkg::HS_HOLD: begin
        // data stays on the pins until the host lets select go
        if (acc.finish) begin
          hs_next    = doah_pkg::HS_IDLE;
          ack_n_next = 1'b1;
          oe_next    = 1'b0;
        end
      end
    endcase
  end

  // all register state resets: ack_n_reg loads 1, hs_reg loads HS_IDLE, the rest clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hs_reg    <= doah_pkg::HS_IDLE;
      phase_reg <= doah_pkg::ADJ_RESET[doah_pkg::PHASE_MSB:
                                       doah_pkg::PHASE_LSB];
      skew_reg  <= doah_pkg::ADJ_RESET[doah_pkg::SKEW_MSB:
                                       doah_pkg::SKEW_LSB];
      fast_reg  <= doah_pkg::HK_RESET[doah_pkg::HK_CLK_BIT];
      dout_reg  <= 16'h0000;
      oe_reg    <= 1'b0;
      ack_n_reg <= 1'b1;
      shift_reg <= 13'sh0;
    end else begin
      hs_reg    <= hs_next;
      phase_reg <= phase_next;
      skew_reg  <= skew_next;
      fast_reg  <= fast_next;
      dout_reg  <= dout_next;
      oe_reg    <= oe_next;
      ack_n_reg <= ack_n_next;
      shift_reg <= shift_next;
    end
  end

  // every output comes from a flip-flop
  assign host_data_out     = dout_reg;
  assign host_data_oe      = oe_reg;
  assign host_ack_n        = ack_n_reg;
  assign phase_offset_word = phase_reg;
  assign output_skew_steps = skew_reg;
  assign fast_clock_select = fast_reg;
  assign output_shift      = shift_reg;

  // ************************************************************
  // checks
  // ************************************************************
  logic signed [12:0] exp_fast;
  logic signed [12:0] exp_t1;
  logic               idle_start;

  // reference shifts computed independently of the calc module
  assign exp_fast = 13'(signed'(phase_reg)) * 13'sd30
                  + 13'(skew_reg) * 13'sd7;
  assign exp_t1   = 13'(signed'(phase_reg)) * 13'sd40
                  + 13'(skew_reg) * 13'sd7;
  assign idle_start = acc.start && (hs_reg == doah_pkg::HS_IDLE);

  a_phase_word_load: assert property (
    @(posedge clk) disable iff (!rst_n)
    idle_start && acc.write && hit_adj |=>
      phase_offset_word == $past(acc.wdata[15:9])
  ) else $error("phase word not loaded from bits 15..9");

  a_shift_fast_ref: assert property (
    @(posedge clk) disable iff (!rst_n)
    active_ref_freq != doah_pkg::REF_1M544 |=>
      output_shift == $past(exp_fast)
  ) else $error("shift wrong for 15 ns step");

  a_shift_t1_ref: assert property (
    @(posedge clk) disable iff (!rst_n)
    active_ref_freq == doah_pkg::REF_1M544 |=>
      output_shift == $past(exp_t1)
  ) else $error("shift wrong for 20 ns step");

  a_skew_load: assert property (
    @(posedge clk) disable iff (!rst_n)
    idle_start && acc.write && hit_adj |=>
      output_skew_steps == $past(acc.wdata[2:0])
  ) else $error("skew count not loaded from bits 2..0");

  a_sec_fail_read: assert property (
    @(posedge clk) disable iff (!rst_n)
    idle_start && !acc.write && hit_hk |=>
      host_data_out[6] == $past(second_monitor_fail) && host_data_oe
  ) else $error("bit 6 does not show secondary fail");

  a_pri_fail_read: assert property (
    @(posedge clk) disable iff (!rst_n)
    idle_start && !acc.write && hit_hk |=>
      host_data_out[5] == $past(first_monitor_fail)
  ) else $error("bit 5 does not show primary fail");

  a_clock_select: assert property (
    @(posedge clk) disable iff (!rst_n)
    idle_start && acc.write && hit_hk |=>
      fast_clock_select == $past(acc.wdata[4]) ##1
      $stable(fast_clock_select) || $past(acc.start)
  ) else $error("clock select not taken from bit 4");

  a_hk_write_only_clk: assert property (
    @(posedge clk) disable iff (!rst_n)
    idle_start && acc.write && hit_hk |=>
      $stable(phase_offset_word) && $stable(output_skew_steps)
  ) else $error("housekeeping write touched adjust fields");

  a_limit_read: assert property (
    @(posedge clk) disable iff (!rst_n)
    idle_start && !acc.write && hit_hk |=>
      host_data_out[3] == $past(limiter_active)
  ) else $error("bit 3 does not show limiter");

  a_state_read: assert property (
    @(posedge clk) disable iff (!rst_n)
    idle_start && !acc.write && hit_hk |=>
      host_data_out[2:0] == $past(pll_state)
  ) else $error("bits 2..0 do not show pll state");

  a_hk_upper_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    idle_start && !acc.write && hit_hk |=>
      host_data_out[15:7] == 9'h000 &&
      host_data_out[4] == $past(fast_clock_select)
  ) else $error("status or reserved bits stored from a write");

  a_ack_release: assert property (
    @(posedge clk) disable iff (!rst_n)
    acc.finish && hs_reg == doah_pkg::HS_HOLD |=>
      host_ack_n && !host_data_oe
  ) else $error("ack or drive not released after select");

  // checked one edge late so a missed time-zero edge cannot trip it
  a_reset_clears_select: assert property (
    @(posedge clk)
    !rst_n |=> !fast_clock_select && host_ack_n && !host_data_oe
  ) else $error("select or port not cleared by reset");

  // the sequencer must always sit in exactly one state
  a_seq_one_hot: assert property (
    @(posedge clk) disable iff (!rst_n)
    $onehot(hs_reg)
  ) else $error("host sequencer state not one-hot");

  // every access taken from idle is answered on the next edge
  a_start_gives_ack: assert property (
    @(posedge clk) disable iff (!rst_n)
    idle_start |=> !host_ack_n && hs_reg == doah_pkg::HS_HOLD
  ) else $error("access start not acknowledged");

  // a write must never turn the data pins around
  a_write_no_drive: assert property (
    @(posedge clk) disable iff (!rst_n)
    idle_start && acc.write |=> !host_data_oe && host_data_out == 16'h0000
  ) else $error("data pins driven during a write");

  // reserved adjust bits read back as zero beside the stored fields
  a_adjust_readback: assert property (
    @(posedge clk) disable iff (!rst_n)
    idle_start && !acc.write && hit_adj |=>
      host_data_out[15:9] == $past(phase_offset_word) &&
      host_data_out[8:3] == 6'h00 &&
      host_data_out[2:0] == $past(output_skew_steps)
  ) else $error("adjust register read back wrong");

endmodule

// File: sim/doah_host_model.sv
/*
 * Host processor model for the parallel register port: one task that
 * makes a single read or write access and reports what came back.
 * Assumes the device answers with an active-low acknowledge.
 */
`timescale 1ns/1ns
module doah_host_model (
  // clock
  input  wire logic        clk,
  // pins driven toward the device
  output logic             host_cs_n,
  output logic             host_rd,
  output logic [13:0]      host_addr,
  output logic [15:0]      host_data_in,
  // answers from the device
  input  wire logic [15:0] host_data_out,
  input  wire logic        host_data_oe,
  input  wire logic        host_ack_n
);
  // ************************************************************
  // idle pins at time zero
  // ************************************************************
  initial begin
    host_cs_n    = 1'b1;
    host_rd      = 1'b1;
    host_addr    = 14'h0000;
    host_data_in = 16'ha5a5;
  end

  // ************************************************************
  // one access: select, wait for ack, release, wait for release
  // ************************************************************
  // address, direction and data change with select and stay put
  // until the acknowledge edge, so the synchroniser never sees a mix
  task automatic access(input logic wr, input logic [13:0] a,
                        input logic [15:0] wd, output logic [15:0] rdata,
                        output logic oe_seen, output logic ok);
    int n;
    n = 0;
    @(posedge clk);
    host_rd      <= ~wr;
    host_addr    <= a;
    host_data_in <= wd;
    host_cs_n    <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (host_ack_n !== 1'b0 && n < 16);
    ok      = (host_ack_n === 1'b0);
    rdata   = host_data_out;
    oe_seen = host_data_oe;
    host_cs_n    <= 1'b1;
    // released data lines do not keep the old value
    host_data_in <= ~wd;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (host_ack_n !== 1'b1 && n < 16);
    // select stays high at least four clocks between accesses
    repeat (4) @(posedge clk);
  endtask
endmodule

// File: sim/doah_top_test.sv
/*
 * Self-checking bench for the phase/skew adjust and housekeeping
 * registers. Assumes the host model and the design share one clock.
 */
`timescale 1ns/1ns
module doah_top_test;
  // ************************************************************
  // signals
  // ************************************************************
  logic               clk;
  logic               rst_n;
  logic               host_cs_n;
  logic               host_rd;
  logic        [13:0] host_addr;
  logic        [15:0] host_data_in;
  logic        [15:0] host_data_out;
  logic               host_data_oe;
  logic               host_ack_n;
  logic               second_monitor_fail;
  logic               first_monitor_fail;
  logic               limiter_active;
  logic        [2:0]  pll_state;
  logic        [1:0]  active_ref_freq;
  logic        [6:0]  phase_offset_word;
  logic        [2:0]  output_skew_steps;
  logic               fast_clock_select;
  logic signed [12:0] output_shift;
  int                 error_cnt;
  int                 n_checks;

  doah_top u_dut (
    .clk                (clk),
    .rst_n              (rst_n),
    .host_cs_n          (host_cs_n),
    .host_rd            (host_rd),
    .host_addr          (host_addr),
    .host_data_in       (host_data_in),
    .host_data_out      (host_data_out),
    .host_data_oe       (host_data_oe),
    .host_ack_n         (host_ack_n),
    .second_monitor_fail(second_monitor_fail),
    .first_monitor_fail (first_monitor_fail),
    .limiter_active     (limiter_active),
    .pll_state          (pll_state),
    .active_ref_freq    (active_ref_freq),
    .phase_offset_word  (phase_offset_word),
    .output_skew_steps  (output_skew_steps),
    .fast_clock_select  (fast_clock_select),
    .output_shift       (output_shift)
  );

  doah_host_model u_host (
    .clk          (clk),
    .host_cs_n    (host_cs_n),
    .host_rd      (host_rd),
    .host_addr    (host_addr),
    .host_data_in (host_data_in),
    .host_data_out(host_data_out),
    .host_data_oe (host_data_oe),
    .host_ack_n   (host_ack_n)
  );

  // ************************************************************
  // clock, time-zero values and watchdog
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // a test run takes about five hundred clocks; nearly forty times that is a hang
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask

  task automatic reg_wr(input logic [13:0] a, input logic [15:0] d);
    logic [15:0] r;
    logic        oe;
    logic        ok;
    u_host.access(1'b1, a, d, r, oe, ok);
    check("write ack", {15'h0000, ok}, 16'h0001);
    check("write oe", {15'h0000, oe}, 16'h0000);
  endtask

  task automatic reg_rd(input logic [13:0] a, input logic [15:0] exp,
                        input string what);
    logic [15:0] r;
    logic        oe;
    logic        ok;
    u_host.access(1'b0, a, 16'h0000, r, oe, ok);
    check("read ack", {15'h0000, ok}, 16'h0001);
    check("read oe", {15'h0000, oe}, 16'h0001);
    check(what, r, exp);
  endtask

  // write one adjust word, then sweep all reference codes; the spare
  // code must fall back to the 15 ns step
  task automatic adj_case(input logic [6:0] ph, input logic [2:0] sk);
    int e;
    reg_wr(doah_pkg::OFS_ADJUST, {ph, 6'h00, sk});
    reg_rd(doah_pkg::OFS_ADJUST, {ph, 6'h00, sk}, "adjust");
    check("phase", {9'h000, phase_offset_word}, {9'h000, ph});
    check("skew", {13'h0000, output_skew_steps}, {13'h0000, sk});
    for (int f = 0; f < 4; f++) begin
      active_ref_freq <= f[1:0];
      repeat (3) @(posedge clk);
      e = int'($signed(ph)) * ((f == 1) ? 40 : 30) + int'(sk) * 7;
      check("shift", 16'($signed(output_shift)), 16'(e));
    end
  endtask

  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    error_cnt           = 0;
    n_checks            = 0;
    rst_n               = 1'b0;
    second_monitor_fail = 1'b0;
    first_monitor_fail  = 1'b0;
    limiter_active      = 1'b0;
    pll_state           = 3'h0;
    active_ref_freq     = 2'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    reg_rd(doah_pkg::OFS_HOUSE, 16'h0000, "hk reset");
    reg_rd(doah_pkg::OFS_ADJUST, 16'h0000, "adjust reset");
    $display("test reset values done");

    // all-ones word, most negative word and a positive word
    adj_case(7'h7f, 3'h7);
    adj_case(7'h40, 3'h0);
    adj_case(7'h3f, 3'h5);
    $display("test phase and skew done");

    // every state code under both clock selections
    for (int fs = 0; fs < 2; fs++) begin
      reg_wr(doah_pkg::OFS_HOUSE, {11'h000, fs[0], 4'h0});
      check("fast sel", {15'h0000, fast_clock_select}, 16'(fs));
      for (int i = 0; i < 8; i++) begin
        pll_state           <= i[2:0];
        second_monitor_fail <= i[0];
        first_monitor_fail  <= i[1];
        limiter_active      <= i[2];
        repeat (2) @(posedge clk);
        reg_rd(doah_pkg::OFS_HOUSE,
               {9'h000, i[0], i[1], fs[0], i[2], i[2:0]},
               "hk status");
      end
    end
    $display("test status bits done");

    // status inputs quiet, then writes aimed at the read-only bits
    second_monitor_fail <= 1'b0;
    first_monitor_fail  <= 1'b0;
    limiter_active      <= 1'b0;
    pll_state           <= 3'h0;
    reg_wr(doah_pkg::OFS_HOUSE, 16'hfff7);
    check("fast kept", {15'h0000, fast_clock_select}, 16'h0001);
    reg_rd(doah_pkg::OFS_HOUSE, 16'h0010, "hk ro write");
    reg_wr(doah_pkg::OFS_HOUSE, 16'h0000);
    check("fast clear", {15'h0000, fast_clock_select}, 16'h0000);
    reg_wr(doah_pkg::OFS_HOUSE, 16'hffff);
    check("fast set", {15'h0000, fast_clock_select}, 16'h0001);
    reg_rd(doah_pkg::OFS_HOUSE, 16'h0010, "hk mixed");
    reg_rd(14'h002f, 16'h0000, "unmapped");
    $display("test write masks done");

    // reset in mid-run clears the stored select and adjust word
    reg_wr(doah_pkg::OFS_ADJUST, 16'h8205);
    do_reset();
    check("fast after rst", {15'h0000, fast_clock_select}, 16'h0000);
    reg_rd(doah_pkg::OFS_HOUSE, 16'h0000, "hk rerun");
    reg_rd(doah_pkg::OFS_ADJUST, 16'h0000, "adjust rerun");
    $display("test second reset done");
    print_verdict();
  end
endmodule
